// [common/jdp_defines.vh]
// constants for the test-port pin logic
`ifndef JDP_DEFINES_VH
`define JDP_DEFINES_VH
`define JDP_ST_TLR 4'h0
`define JDP_ST_RTI 4'h1
`define JDP_ST_SDS 4'h2
`define JDP_ST_CDR 4'h3
`define JDP_ST_SDR 4'h4
`define JDP_ST_E1D 4'h5
`define JDP_ST_PDR 4'h6
`define JDP_ST_E2D 4'h7
`define JDP_ST_UDR 4'h8
`define JDP_ST_SIS 4'h9
`define JDP_ST_CIR 4'ha
`define JDP_ST_SIR 4'hb
`define JDP_ST_E1I 4'hc
`define JDP_ST_PIR 4'hd
`define JDP_ST_E2I 4'he
`define JDP_ST_UIR 4'hf
`define JDP_IR_W 4
`define JDP_IR_RST 4'h1
`define JDP_IR_BYPASS 4'hf
`define JDP_IR_DATA 4'h2
`define JDP_DR_W 16
`define JDP_DR_RST 16'h0000
`define JDP_EVT_PULSE 4'h8
`define JDP_FIFO_W 16
`define JDP_FIFO_D 16
`define JDP_FIFO_AW 4
`endif

// [hw/jdp_fifo.v]
// parameterised first-in first-out buffer
`timescale 1ns/10ps
`default_nettype none
module jdp_fifo #(
  parameter W = 16,
  parameter D = 16,
  parameter AW = 4
)
(
  // clock and reset
  input wire clk,
  input wire resetn,
  // write side
  input wire in_valid,
  output wire in_ready,
  input wire [W-1:0] in_data,
  // read side
  output wire out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data
);
  reg [W-1:0] mem [0:D-1];
  reg [AW-1:0] wr_reg;
  reg [AW-1:0] rd_reg;
  reg [AW:0] cnt_reg;
  wire push;
  wire pop;
  assign in_ready = (cnt_reg != D[AW:0]);
  assign out_valid = (cnt_reg != {(AW+1){1'b0}});
  assign out_data = mem[rd_reg];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  always @(posedge clk)
  begin
    if (push)
      mem[wr_reg] <= in_data;
  end
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wr_reg <= {AW{1'b0}};
      rd_reg <= {AW{1'b0}};
      cnt_reg <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wr_reg <= wr_reg + 1'b1;
      if (pop)
        rd_reg <= rd_reg + 1'b1;
      if (push & ~pop)
        cnt_reg <= cnt_reg + 1'b1;
      else if (pop & ~push)
        cnt_reg <= cnt_reg - 1'b1;
    end
  end
endmodule
`default_nettype wire

// [hw/jdp_port.v]
// test access port pin logic with debug-event output
`timescale 1ns/10ps
`default_nettype none
`include "jdp_defines.vh"
module jdp_port
(
  // clock and reset
  input wire clk,
  input wire resetn,
  // test port pins
  input wire tck,
  input wire tms,
  input wire tdi,
  output reg tdo_out,
  output reg tdo_oe,
  // shared test reset / debug event pin
  input wire trstn_in,
  output reg debug_event_out,
  output reg debug_event_oe,
  // debug side
  input wire debug_event_mode,
  input wire debug_event,
  // data register words shifted in, to the core
  output reg [`JDP_DR_W-1:0] rx_data,
  output reg rx_valid,
  input wire rx_ready,
  // words to shift out
  input wire [`JDP_DR_W-1:0] tx_data,
  input wire tx_valid,
  output reg tx_ready,
  // state view
  output reg [3:0] tap_state
);
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  reg [1:0] tck_s_reg;
  reg [1:0] tms_s_reg;
  reg [1:0] tdi_s_reg;
  reg [1:0] trst_s_reg;
  reg tck_d_reg;
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      tck_s_reg <= 2'h0;
      tms_s_reg <= 2'h3;
      tdi_s_reg <= 2'h3;
      trst_s_reg <= 2'h3;
      tck_d_reg <= 1'b0;
    end
    else
    begin
      tck_s_reg <= {tck_s_reg[0], tck};
      tms_s_reg <= {tms_s_reg[0], tms};
      tdi_s_reg <= {tdi_s_reg[0], tdi};
      trst_s_reg <= {trst_s_reg[0], trstn_in};
      tck_d_reg <= tck_s_reg[1];
    end
  end
  wire tck_rise = tck_s_reg[1] & ~tck_d_reg;
  wire tck_fall = ~tck_s_reg[1] & tck_d_reg;
  wire tms_s = tms_s_reg[1];
  wire tdi_s = tdi_s_reg[1];
  // shared pin only resets while it is an input
  wire test_rst = ~trst_s_reg[1] & ~debug_event_mode;
  // ----------------------------------------
  // state machine
  // ----------------------------------------
  function [3:0] tap_next;
    input [3:0] s;
    input m;
    begin
      case (s)
        `JDP_ST_TLR: tap_next = m ? `JDP_ST_TLR : `JDP_ST_RTI;
        `JDP_ST_RTI: tap_next = m ? `JDP_ST_SDS : `JDP_ST_RTI;
        `JDP_ST_SDS: tap_next = m ? `JDP_ST_SIS : `JDP_ST_CDR;
        `JDP_ST_CDR: tap_next = m ? `JDP_ST_E1D : `JDP_ST_SDR;
        `JDP_ST_SDR: tap_next = m ? `JDP_ST_E1D : `JDP_ST_SDR;
        `JDP_ST_E1D: tap_next = m ? `JDP_ST_UDR : `JDP_ST_PDR;
        `JDP_ST_PDR: tap_next = m ? `JDP_ST_E2D : `JDP_ST_PDR;
        `JDP_ST_E2D: tap_next = m ? `JDP_ST_UDR : `JDP_ST_SDR;
        `JDP_ST_UDR: tap_next = m ? `JDP_ST_SDS : `JDP_ST_RTI;
        `JDP_ST_SIS: tap_next = m ? `JDP_ST_TLR : `JDP_ST_CIR;
        `JDP_ST_CIR: tap_next = m ? `JDP_ST_E1I : `JDP_ST_SIR;
        `JDP_ST_SIR: tap_next = m ? `JDP_ST_E1I : `JDP_ST_SIR;
        `JDP_ST_E1I: tap_next = m ? `JDP_ST_UIR : `JDP_ST_PIR;
        `JDP_ST_PIR: tap_next = m ? `JDP_ST_E2I : `JDP_ST_PIR;
        `JDP_ST_E2I: tap_next = m ? `JDP_ST_UIR : `JDP_ST_SIR;
        `JDP_ST_UIR: tap_next = m ? `JDP_ST_SDS : `JDP_ST_RTI;
        default: tap_next = `JDP_ST_TLR;
      endcase
    end
  endfunction
  // ----------------------------------------
  // shift registers
  // ----------------------------------------
  reg [`JDP_IR_W-1:0] ir_sh_reg;
  reg [`JDP_IR_W-1:0] ir_reg;
  reg [`JDP_DR_W-1:0] dr_sh_reg;
  reg byp_reg;
  reg out_bit;
  wire data_sel = (ir_reg == `JDP_IR_DATA);
  wire [`JDP_DR_W-1:0] f_data;
  wire f_valid;
  reg f_pop;
  // words captured at update-data go out through the buffer
  reg push_reg;
  wire push_ready;
  jdp_fifo #(
    .W(`JDP_FIFO_W),
    .D(`JDP_FIFO_D),
    .AW(`JDP_FIFO_AW)
  ) u_fifo (
    .clk(clk),
    .resetn(resetn),
    .in_valid(push_reg),
    .in_ready(push_ready),
    .in_data(dr_sh_reg),
    .out_valid(f_valid),
    .out_ready(f_pop),
    .out_data(f_data)
  );
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      tap_state <= `JDP_ST_TLR;
      ir_sh_reg <= `JDP_IR_RST;
      ir_reg <= `JDP_IR_RST;
      dr_sh_reg <= `JDP_DR_RST;
      byp_reg <= 1'b0;
      push_reg <= 1'b0;
    end
    else if (test_rst)
    begin
      tap_state <= `JDP_ST_TLR;
      ir_reg <= `JDP_IR_RST;
      push_reg <= 1'b0;
    end
    else
    begin
      push_reg <= 1'b0;
      if (tck_rise)
      begin
        tap_state <= tap_next(tap_state, tms_s);
        case (tap_state)
          `JDP_ST_TLR: ir_reg <= `JDP_IR_RST;
          `JDP_ST_CIR: ir_sh_reg <= `JDP_IR_RST;
          `JDP_ST_SIR: ir_sh_reg <= {tdi_s, ir_sh_reg[`JDP_IR_W-1:1]};
          `JDP_ST_UIR: ir_reg <= ir_sh_reg;
          `JDP_ST_CDR:
          begin
            byp_reg <= 1'b0;
            if (tx_valid)
              dr_sh_reg <= tx_data;
          end
          `JDP_ST_SDR:
          begin
            if (data_sel)
              dr_sh_reg <= {tdi_s, dr_sh_reg[`JDP_DR_W-1:1]};
            else
              byp_reg <= tdi_s;
          end
          `JDP_ST_UDR: push_reg <= data_sel & push_ready;
          default: ir_reg <= ir_reg;
        endcase
      end
    end
  end
  always @*
  begin
    out_bit = 1'b0;
    case (tap_state)
      `JDP_ST_SIR: out_bit = ir_sh_reg[0];
      `JDP_ST_SDR: out_bit = data_sel ? dr_sh_reg[0] : byp_reg;
      default: out_bit = 1'b0;
    endcase
  end
  // ----------------------------------------
  // data output, changed on falling test clock; enable also cleared by test reset
  // ----------------------------------------
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      tdo_out <= 1'b0;
      tdo_oe <= 1'b0;
    end
    else if (test_rst)
      tdo_oe <= 1'b0;
    else if (tck_fall)
    begin
      tdo_out <= out_bit;
      tdo_oe <= (tap_state == `JDP_ST_SIR) |
                (tap_state == `JDP_ST_SDR);
    end
  end
  // ----------------------------------------
  // receive words and debug event pulse
  // ----------------------------------------
  reg [3:0] evt_cnt_reg;
  always @*
  begin
    f_pop = f_valid & (~rx_valid | rx_ready);
  end
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rx_valid <= 1'b0;
      tx_ready <= 1'b0;
      rx_data <= `JDP_DR_RST;
      evt_cnt_reg <= 4'h0;
      debug_event_out <= 1'b1;
      debug_event_oe <= 1'b0;
    end
    else
    begin
      if (f_pop)
      begin
        rx_valid <= 1'b1;
        rx_data <= f_data;
      end
      else if (rx_ready)
        rx_valid <= 1'b0;
      tx_ready <= tck_rise & ~test_rst & data_sel &
                  (tap_state == `JDP_ST_CDR);
      debug_event_oe <= debug_event_mode;
      if (debug_event_mode & debug_event & (evt_cnt_reg == 4'h0))
        evt_cnt_reg <= `JDP_EVT_PULSE;
      else if (evt_cnt_reg != 4'h0)
        evt_cnt_reg <= evt_cnt_reg - 4'h1;
      debug_event_out <= ~(debug_event_mode &
        ((debug_event & (evt_cnt_reg == 4'h0)) | (evt_cnt_reg > 4'h1)));
    end
  end
endmodule
`default_nettype wire

// [verification/jdp_props.sv]
// assertions on the test-port pin logic
`timescale 1ns/10ps
`default_nettype none
module jdp_props
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // pins and debug side
  input wire logic tck,
  input wire logic trstn_in,
  input wire logic tdo_out,
  input wire logic tdo_oe,
  input wire logic debug_event_out,
  input wire logic debug_event_oe,
  input wire logic debug_event_mode,
  input wire logic debug_event,
  input wire logic [3:0] tap_state
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  property p_on; $rose(tdo_oe) |-> tap_state inside {4'h4, 4'hb}; endproperty
  a_on: assert property (p_on) else $error("tdo on");
  property p_off; $fell(tdo_oe) |-> !(tap_state inside {4'h4, 4'hb});
  endproperty
  a_off: assert property (p_off) else $error("tdo off");
  property p_fall; $changed(tdo_out) |-> !$past(tck) && !$past(tck, 2);
  endproperty
  a_fall: assert property (p_fall) else $error("tdo moved");
  property p_rise; $changed(tap_state) |-> $past(tck, 2) || tap_state == 4'h0;
  endproperty
  a_rise: assert property (p_rise) else $error("state moved");
  property p_trst; (!trstn_in && !debug_event_mode) [*6] |-> tap_state == 4'h0;
  endproperty
  a_trst: assert property (p_trst) else $error("no test reset");
  property p_ign; (debug_event_mode && !tck) [*8] |=> $stable(tap_state);
  endproperty
  a_ign: assert property (p_ign) else $error("idle move");
  property p_len; $fell(debug_event_out) |->
    (!debug_event_out) [*8] ##1 debug_event_out; endproperty
  a_len: assert property (p_len) else $error("pulse length");
  property p_why; $fell(debug_event_out) |-> debug_event_oe &&
    ($past(debug_event) || $past(debug_event, 2) || $past(debug_event, 3));
  endproperty
  a_why: assert property (p_why) else $error("pulse cause");
endmodule
bind jdp_port jdp_props chk (
  .clk(clk),
  .resetn(resetn),
  .tck(tck),
  .trstn_in(trstn_in),
  .tdo_out(tdo_out),
  .tdo_oe(tdo_oe),
  .debug_event_out(debug_event_out),
  .debug_event_oe(debug_event_oe),
  .debug_event_mode(debug_event_mode),
  .debug_event(debug_event),
  .tap_state(tap_state)
);
`default_nettype wire

// [verification/jdp_probe.sv]
// test controller model driving the test clock, mode and data pins
`timescale 1ns/10ps
`default_nettype none
module jdp_probe
(
  // clock
  input wire logic clk,
  // test pins
  output var logic tck,
  output var logic tms,
  output var logic tdi,
  input wire logic tdo_out,
  input wire logic tdo_oe
);
  // clock stands low between frames, pins at pull-up level
  initial
  begin
    tck = 1'h0;
    tms = 1'h1;
    tdi = 1'h1;
  end
  // one 80 ns test clock period, tdo taken just after the rise
  task automatic step(input logic m, input logic d, output logic o);
    @(posedge clk);
    tms <= m;
    tdi <= d;
    repeat (3) @(posedge clk);
    tck <= 1'h1;
    @(posedge clk);
    o = tdo_oe ? tdo_out : 1'hz;
    repeat (3) @(posedge clk);
    tck <= 1'h0;
  endtask
endmodule
`default_nettype wire

// [verification/test_jtag_debug_port_pins.sv]
// self-checking bench for the test-port pin logic
`timescale 1ns/10ps
`default_nettype none
`include "jdp_defines.vh"
module test_jtag_debug_port_pins;
  logic clk, resetn, tck, tms, tdi, tdo_out, tdo_oe, trstn_in, o;
  logic debug_event_out, debug_event_oe, debug_event_mode, debug_event;
  logic rx_valid, rx_ready, tx_valid, tx_ready;
  logic [15:0] rx_data, tx_data, got, w;
  logic [3:0] tap_state, exp;
  logic [31:0] seed;
  int errors, num_checks;
  int tx_takes;
  jdp_port uut (
    .clk(clk),
    .resetn(resetn),
    .tck(tck),
    .tms(tms),
    .tdi(tdi),
    .tdo_out(tdo_out),
    .tdo_oe(tdo_oe),
    .trstn_in(trstn_in),
    .debug_event_out(debug_event_out),
    .debug_event_oe(debug_event_oe),
    .debug_event_mode(debug_event_mode),
    .debug_event(debug_event),
    .rx_data(rx_data),
    .rx_valid(rx_valid),
    .rx_ready(rx_ready),
    .tx_data(tx_data),
    .tx_valid(tx_valid),
    .tx_ready(tx_ready),
    .tap_state(tap_state)
  );
  jdp_probe probe (
    .clk(clk),
    .tck(tck),
    .tms(tms),
    .tdi(tdi),
    .tdo_out(tdo_out),
    .tdo_oe(tdo_oe)
  );
  // count words taken at capture-data
  always @(posedge clk)
  begin
    if (tx_ready === 1'b1)
      tx_takes++;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [3:0] nxt(input logic [3:0] s, input logic m);
    logic [63:0] t;
    t = m ? 64'h2fefcc0287855920 : 64'h1bddbba146644311;
    return t[s*4 +: 4];
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    num_checks++;
    if (seen !== want)
    begin
      errors++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic go(input logic m, input logic d);
    probe.step(m, d, o);
    @(negedge clk);
    exp = nxt(exp, m);
    check(tap_state, exp);
  endtask
  task automatic scan(input logic ir, input int n, input logic [15:0] d);
    go(1'h1, 1'h0);
    if (ir)
      go(1'h1, 1'h0);
    go(1'h0, 1'h0);
    go(1'h0, 1'h0);
    for (int i = 0; i < n; i++)
    begin
      go(i == n - 1, d[i]);
      got[i] = o;
    end
    go(1'h1, 1'h0);
    go(1'h0, 1'h0);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    repeat (5000) @(posedge clk);
    errors++;
    summarize();
  end
  initial
  begin
    {resetn, trstn_in, debug_event_mode, debug_event, rx_ready} = 5'h00;
    tx_valid = 1'h1;
    tx_data = 16'h0000;
    seed = 32'h1802;
    exp = 4'h0;
    repeat (5) @(posedge clk);
    resetn <= 1'h1;
    trstn_in <= 1'h1;
    @(negedge clk);
    check(tdo_oe, 1'h0);
    check(tap_state, 4'h0);
    go(1'h0, 1'h0);
    scan(1'h1, 4, `JDP_IR_DATA);
    for (int k = 0; k < 4; k++)
    begin
      seed = lfsr(seed);
      w = k ? seed[15:0] : 16'h7ffe;
      @(posedge clk);
      tx_data <= k ? seed[31:16] : 16'h8001;
      scan(1'h0, 16, w);
      repeat (2) @(negedge clk);
      check(got, tx_data);
      check(tx_takes[15:0], k[15:0] + 16'h1);
      check(rx_valid, 1'h1);
      check(rx_data, w);
      @(posedge clk);
      rx_ready <= 1'h1;
      @(posedge clk);
      rx_ready <= 1'h0;
      @(negedge clk);
      check(rx_valid, 1'h0);
    end
    @(posedge clk);
    debug_event_mode <= 1'h1;
    repeat (2) @(posedge clk);
    debug_event <= 1'h1;
    @(posedge clk);
    debug_event <= 1'h0;
    repeat (3) @(negedge clk);
    check(debug_event_out, 1'h0);
    check(debug_event_oe, 1'h1);
    @(posedge clk);
    trstn_in <= 1'h0;
    repeat (10) @(negedge clk);
    check(tap_state, exp);
    @(posedge clk);
    debug_event_mode <= 1'h0;
    repeat (10) @(negedge clk);
    check(tap_state, 4'h0);
    exp = 4'h0;
    @(posedge clk);
    trstn_in <= 1'h1;
    repeat (40)
    begin
      seed = lfsr(seed);
      @(posedge clk);
      rx_ready <= seed[2];
      go(seed[0], seed[1]);
    end
    summarize();
  end
endmodule
`default_nettype wire
